// >>> design/fps_stages.sv
/*
 * Eight frequency stages with timer, events, records and AXI4-Lite slave.
 * Assumes frequency, voltage and block inputs come from logic on aclk.
 */
`timescale 1ns/10ps
module fps_stages import fps_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Measurements, 0.01 Hz and 0.01 %Un units
  input wire logic [13:0] freq_pri,
  input wire logic [13:0] freq_sec,
  input wire logic [13:0] freq_ter,
  input wire logic [13:0] volt_meas,
  input wire logic [7:0] block_in,
  // Stage outputs, bits 3:0 over, 7:4 under
  output logic [7:0] start_o,
  output logic [7:0] trip_o,
  output logic [7:0] blocked_o,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] ctrl_r;  // Enables, mode, ref select, event edges
  logic [1:0] global_r;  // Allow mode, enable forcing
  logic [15:0] force_r;  // Forced condition per stage
  logic [2:0] group_r;  // Active setting group
  logic [13:0] uvthr_r;  // Undervoltage block threshold
  logic [5:0] setidx_r;  // Group*8+stage for setting window
  logic [31:0] set_mem [NGRP*NSTG];  // Level, use flag, delay ticks
  logic [3:0] status_r, mask_r;  // Sticky events and their mask
  logic [31:0] event_r;  // Last filtered event
  logic [3:0] recidx_r, rec_wp_r;
  logic [31:0] rec_a [NREC];
  logic [31:0] rec_b [NREC];
  logic [31:0] rec_ts [NREC];
  logic [31:0] ratio_r [NSTG];
  logic [31:0] tick_cnt_r, stamp_r;
  logic tick;
  logic [13:0] hist_r [PRE_TRIG_N];  // Frequency history, one per tick
  fps_stage_t st_r [NSTG];
  logic [17:0] dly_cnt_r [NSTG];
  logic [15:0] cond_w;
  logic [7:0] ev_start, ev_trip, ev_blk;

  wire [2:0] mode = ctrl_r[10:8];
  wire [1:0] ref_sel = ctrl_r[13:12];
  wire mode_off = (mode == MODE_OFF);
  wire mode_blk = (mode == MODE_BLK) || (mode == MODE_TBLK);
  wire mode_test = (mode == MODE_TEST) || (mode == MODE_TBLK);
  // Reference selection; unused code falls back to primary
  wire [13:0] f_meas = (ref_sel == 2'h1) ? freq_sec :
                       (ref_sel == 2'h2) ? freq_ter : freq_pri;
  // Zero threshold disables the voltage block
  wire uv_blk = (uvthr_r != 14'h0000) && (volt_meas < uvthr_r);

  ////////////////////////////////////////////////////////////////////////
  // Program cycle divider and time stamp
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_r <= 32'h0000_0000;
      stamp_r <= 32'h0000_0000;
    end else if (tick_cnt_r == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= 32'h0000_0000;
      stamp_r <= stamp_r + 32'h0000_0001;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end
  assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

  // History line; last entry is the frequency one pre-trigger span ago
  always_ff @(posedge aclk) begin
    if (tick) begin
      hist_r[0] <= f_meas;
      for (int i = 1; i < PRE_TRIG_N; i++) begin
        hist_r[i] <= hist_r[i-1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stages
  genvar g;
  generate
    for (g = 0; g < NSTG; g++) begin : g_stage
      localparam bit OVER = (g < NOVER);  // Four of each kind
      // Active group's settings switch at once
      wire [31:0] set_w = set_mem[{group_r, 3'(g)}];
      wire [13:0] lvl = set_w[13:0];
      wire [17:0] dly = set_w[31:14];
      wire live = ctrl_r[g] && set_w[15] && !mode_off;
      // Pick-up and release with fixed hysteresis
      wire pick = OVER ? (f_meas > lvl) : (f_meas < lvl);
      wire hold = OVER ? (f_meas > lvl - HYST) : (f_meas < lvl + HYST);
      wire blk = block_in[g] || mode_blk || (!OVER && uv_blk);
      // Stage timer, updated once per program cycle
      always_ff @(posedge aclk) begin
        if (!aresetn || !live) begin
          st_r[g] <= S_IDLE;
          dly_cnt_r[g] <= 18'h00000;
        end else if (tick) begin
          case (st_r[g])
            S_IDLE: begin
              // Block at pick-up gives blocked instead of start
              if (pick && blk) st_r[g] <= S_BLOCKED;
              else if (pick) st_r[g] <= S_START;
              dly_cnt_r[g] <= 18'h00000;
            end
            S_START: begin
              // Definite-time delay in program cycles
              if (!hold || blk) st_r[g] <= S_IDLE;
              else if (dly_cnt_r[g] >= dly) st_r[g] <= S_TRIP;
              else dly_cnt_r[g] <= dly_cnt_r[g] + 18'h00001;
            end
            S_TRIP: begin
              if (!hold) st_r[g] <= S_IDLE;
            end
            S_BLOCKED: begin
              if (!hold) st_r[g] <= S_IDLE;
            end
            default: st_r[g] <= S_IDLE;
          endcase
        end
      end
      // Outputs; test mode keeps trips off the port
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          start_o[g] <= 1'b0;
          trip_o[g] <= 1'b0;
          blocked_o[g] <= 1'b0;
        end else begin
          start_o[g] <= (st_r[g] == S_START) || (st_r[g] == S_TRIP);
          trip_o[g] <= (st_r[g] == S_TRIP) && !mode_test;
          blocked_o[g] <= (st_r[g] == S_BLOCKED);
        end
      end
      // Reported condition, forced when forcing enabled
      wire [1:0] real_c = (st_r[g] == S_TRIP) ? C_TRIP :
                          (st_r[g] == S_START) ? C_START :
                          (st_r[g] == S_BLOCKED) ? C_BLOCKED : C_NORMAL;
      assign cond_w[2*g+1:2*g] = global_r[1] ? force_r[2*g+1:2*g] : real_c;
      assign ev_start[g] = start_o[g] != ((st_r[g] == S_START) ||
                                          (st_r[g] == S_TRIP));
      assign ev_trip[g] = trip_o[g] != ((st_r[g] == S_TRIP) && !mode_test);
      assign ev_blk[g] = blocked_o[g] != (st_r[g] == S_BLOCKED);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Serial ratio divider, one stage at a time, level*1000/f
  logic [2:0] dv_stg_r;
  logic [4:0] dv_bit_r;
  logic [23:0] dv_num_r, dv_quo_r;
  logic [14:0] dv_rem_r;
  wire [13:0] dv_lvl = set_mem[{group_r, dv_stg_r}][13:0];
  wire [14:0] dv_trial = {dv_rem_r[13:0], dv_num_r[23]};
  wire dv_fit = dv_trial >= {1'b0, f_meas};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dv_stg_r <= 3'h0;
      dv_bit_r <= 5'h00;
    end else if (dv_bit_r == 5'h00) begin
      dv_num_r <= 24'(dv_lvl * RATIO_SCALE);
      dv_rem_r <= 15'h0000;
      dv_quo_r <= 24'h000000;
      dv_bit_r <= 5'h18;
    end else begin
      dv_num_r <= {dv_num_r[22:0], 1'b0};
      dv_rem_r <= dv_fit ? dv_trial - {1'b0, f_meas} : dv_trial;
      dv_quo_r <= {dv_quo_r[22:0], dv_fit};
      dv_bit_r <= dv_bit_r - 5'h01;
      if (dv_bit_r == 5'h01) begin
        ratio_r[dv_stg_r] <= (f_meas == 14'h0000 ||
          {dv_quo_r[22:0], dv_fit} > RATIO_MAX) ? 32'(RATIO_MAX)
          : 32'({dv_quo_r[22:0], dv_fit});
        dv_stg_r <= dv_stg_r + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Events: lowest stage wins when several change in one cycle
  logic [2:0] ev_stg;
  logic [1:0] ev_kind;
  logic ev_any, ev_on;
  always_comb begin
    ev_any = 1'b0;
    ev_stg = 3'h0;
    ev_kind = 2'h0;
    for (int i = NSTG - 1; i >= 0; i--) begin
      if (ev_start[i] || ev_trip[i] || ev_blk[i]) begin
        ev_any = 1'b1;
        ev_stg = 3'(i);
        ev_kind = ev_trip[i] ? 2'h1 : ev_blk[i] ? 2'h2 : 2'h0;
      end
    end
    ev_on = (ev_kind == 2'h1) ? !trip_o[ev_stg] :
            (ev_kind == 2'h2) ? !blocked_o[ev_stg] : !start_o[ev_stg];
  end
  wire ev_keep = ev_any && (ev_on ? ctrl_r[16] : ctrl_r[17]);
  wire rec_take = ev_any && ev_on;  // Records hold ON edges

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic aw_full_r, w_full_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  wire wr_go = aw_full_r && w_full_r && !s_axi_bvalid;
  wire [31:0] wd = w_data_r;
  wire wr_ctrl = wr_go && (aw_addr_r == A_CTRL);
  wire wr_glob = wr_go && (aw_addr_r == A_GLOBAL);
  wire wr_force = wr_go && (aw_addr_r == A_FORCE);
  wire wr_group = wr_go && (aw_addr_r == A_GROUP);
  wire wr_uv = wr_go && (aw_addr_r == A_UVTHR);
  wire wr_idx = wr_go && (aw_addr_r == A_SETIDX);
  wire wr_set = wr_go && (aw_addr_r == A_SETDATA);
  wire wr_stat = wr_go && (aw_addr_r == A_STATUS);
  wire wr_mask = wr_go && (aw_addr_r == A_MASK);
  wire wr_ridx = wr_go && (aw_addr_r == A_RECIDX);
  wire wr_ro = (aw_addr_r == A_COND) || (aw_addr_r == A_RATIO) ||
               (aw_addr_r == A_EVENT) || (aw_addr_r == A_RECA) ||
               (aw_addr_r == A_RECB) || (aw_addr_r == A_RECTS);
  wire wr_ok = wr_ctrl || wr_glob || wr_force || wr_group || wr_uv ||
               wr_idx || wr_set || wr_stat || wr_mask || wr_ridx ||
               (wr_go && wr_ro);
  // Mode field only changes when individual mode setting is allowed
  wire [2:0] mode_nxt = (global_r[0] && wd[10:8] <= MODE_OFF) ?
                        wd[10:8] : mode;
  wire [3:0] ev_set = {rec_take, ev_keep && ev_kind == 2'h2,
                       ev_keep && ev_kind == 2'h1, ev_keep && ev_kind == 2'h0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_full_r <= 1'b1;
      else if (wr_go) aw_full_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) w_full_r <= 1'b1;
      else if (wr_go) w_full_r <= 1'b0;
      if (wr_go) s_axi_bvalid <= 1'b1;
      else if (s_axi_bready) s_axi_bvalid <= 1'b0;
      if (wr_go) s_axi_bresp <= wr_ok ? RESP_OK : RESP_ERR;
    end
  end
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) aw_addr_r <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) w_data_r <= s_axi_wdata;
  end
  // Ready only while the holding slot is free
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_full_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_full_r && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // Static settings, untouched by group switching
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      global_r <= 2'h0;
      force_r <= 16'h0000;
      group_r <= 3'h0;
      uvthr_r <= 14'h0000;
      setidx_r <= 6'h00;
      mask_r <= 4'h0;
      recidx_r <= 4'h0;
    end else begin
      if (wr_ctrl) ctrl_r <= {14'h0000, wd[17:16], 2'h0, wd[13:12],
                              1'b0, mode_nxt, wd[7:0]};
      if (wr_glob) global_r <= wd[1:0];
      if (wr_force) force_r <= wd[15:0];
      if (wr_group) group_r <= wd[2:0];
      if (wr_uv) uvthr_r <= wd[13:0];
      if (wr_idx) setidx_r <= wd[5:0];
      if (wr_mask) mask_r <= wd[3:0];
      if (wr_ridx) recidx_r <= (wd[3:0] < 4'(NREC)) ? wd[3:0] : 4'h0;
    end
  end
  // Per-group settings; reset gives use off and default levels
  always_ff @(posedge aclk) begin
    for (int i = 0; i < NGRP * NSTG; i++) begin
      if (!aresetn) begin
        set_mem[i] <= {18'h00000, (i % NSTG < NOVER) ? LVL_OVER_RST
                                                     : LVL_UNDER_RST};
      end else if (wr_set && setidx_r == 6'(i)) begin
        set_mem[i] <= wd;
      end
    end
  end
  // Sticky status, a new event wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= 4'h0;
      irq <= 1'b0;
      event_r <= 32'h0000_0000;
      rec_wp_r <= 4'h0;
    end else begin
      status_r <= (status_r & ~(wr_stat ? wd[3:0] : 4'h0)) | ev_set;
      irq <= |(status_r & mask_r);
      if (ev_keep) event_r <= {stamp_r[23:0], 2'h0, ev_on, ev_kind, ev_stg};
      if (rec_take) begin
        rec_wp_r <= (rec_wp_r == 4'(NREC - 1)) ? 4'h0 : rec_wp_r + 4'h1;
      end
    end
  end
  // Operation records: event, group, pre-trigger and fault frequency
  always_ff @(posedge aclk) begin
    if (rec_take) begin
      rec_a[rec_wp_r] <= {23'h000000, group_r, ev_on, ev_kind, ev_stg};
      rec_b[rec_wp_r] <= {2'h0, f_meas, 2'h0, hist_r[PRE_TRIG_N-1]};
      rec_ts[rec_wp_r] <= stamp_r;
    end
  end

  // Read path
  wire [31:0] rd_mux =
    (s_axi_araddr == A_CTRL) ? ctrl_r :
    (s_axi_araddr == A_GLOBAL) ? {30'h0, global_r} :
    (s_axi_araddr == A_FORCE) ? {16'h0000, force_r} :
    (s_axi_araddr == A_GROUP) ? {29'h0, group_r} :
    (s_axi_araddr == A_UVTHR) ? {18'h0, uvthr_r} :
    (s_axi_araddr == A_SETIDX) ? {26'h0, setidx_r} :
    (s_axi_araddr == A_SETDATA) ? set_mem[setidx_r] :
    (s_axi_araddr == A_COND) ? {16'h0000, cond_w} :
    (s_axi_araddr == A_RATIO) ? ratio_r[setidx_r[2:0]] :
    (s_axi_araddr == A_EVENT) ? event_r :
    (s_axi_araddr == A_STATUS) ? {28'h0, status_r} :
    (s_axi_araddr == A_MASK) ? {28'h0, mask_r} :
    (s_axi_araddr == A_RECIDX) ? {20'h0, rec_wp_r, 4'h0, recidx_r} :
    (s_axi_araddr == A_RECA) ? rec_a[recidx_r] :
    (s_axi_araddr == A_RECB) ? rec_b[recidx_r] :
    (s_axi_araddr == A_RECTS) ? rec_ts[recidx_r] : 32'h0000_0000;
  wire rd_ok = (s_axi_araddr <= A_RECTS) && (s_axi_araddr[1:0] == 2'h0);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OK;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_ok ? rd_mux : 32'h0000_0000;
        s_axi_rresp <= rd_ok ? RESP_OK : RESP_ERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_dis_quiet;
    @(posedge aclk) disable iff (!aresetn)
    !ctrl_r[0] |=> ##1 !start_o[0] && !trip_o[0];
  endproperty
  a_dis_quiet: assert property (p_dis_quiet)
    else $error("disabled out");
  property p_off_quiet;
    @(posedge aclk) disable iff (!aresetn)
    mode_off [*2] |=> start_o == 8'h00 && blocked_o == 8'h00;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("off out");
  property p_excl;
    @(posedge aclk) disable iff (!aresetn) !(start_o[4] && blocked_o[4]);
  endproperty
  a_excl: assert property (p_excl) else $error("start and block");
  property p_trip_after_start;
    @(posedge aclk) disable iff (!aresetn)
    $rose(trip_o[0]) |-> $past(start_o[0]);
  endproperty
  a_trip_after_start: assert property (p_trip_after_start)
    else $error("trip w/o start");
  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
    |(status_r & mask_r) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  property p_bhold;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_force;
    @(posedge aclk) disable iff (!aresetn)
    !global_r[1] && st_r[0] == S_TRIP |-> cond_w[1:0] == C_TRIP;
  endproperty
  a_force: assert property (p_force) else $error("cond lost");
  property p_rec_wrap;
    @(posedge aclk) disable iff (!aresetn)
    rec_take && rec_wp_r == 4'(NREC - 1) |=> rec_wp_r == 4'h0;
  endproperty
  a_rec_wrap: assert property (p_rec_wrap) else $error("rec wrap");
  c_trip: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(trip_o[0]));
  c_block: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(blocked_o[5]));
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
endmodule : fps_stages

// >>> inc/fps_pkg.sv
/*
 * Constants, register map and types of the frequency protection stages.
 * Assumes a 250 MHz clock and AXI4-Lite register access with 32-bit data.
 */
package fps_pkg;
  // Clock and program cycle
  localparam int CLK_MHZ = 250;
  localparam int TICK_US = 5000;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int PRE_TRIG_MS = 20;
  localparam int PRE_TRIG_N = PRE_TRIG_MS * 1000 / TICK_US;
  // Stages, groups, records
  localparam int NSTG = 8;
  localparam int NOVER = 4;
  localparam int NGRP = 8;
  localparam int NREC = 12;
  localparam logic [13:0] HYST = 14'h0002;  // 20 mHz in 0.01 Hz steps
  localparam logic [13:0] LVL_OVER_RST = 14'h13ec;  // 51.00 Hz
  localparam logic [13:0] LVL_UNDER_RST = 14'h1324;  // 49.00 Hz
  localparam logic [23:0] RATIO_SCALE = 24'h0003e8;
  localparam logic [23:0] RATIO_MAX = 24'h004e20;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_GLOBAL = 8'h04;
  localparam logic [7:0] A_FORCE = 8'h08;
  localparam logic [7:0] A_GROUP = 8'h0c;
  localparam logic [7:0] A_UVTHR = 8'h10;
  localparam logic [7:0] A_SETIDX = 8'h14;
  localparam logic [7:0] A_SETDATA = 8'h18;
  localparam logic [7:0] A_COND = 8'h1c;
  localparam logic [7:0] A_RATIO = 8'h20;
  localparam logic [7:0] A_EVENT = 8'h24;
  localparam logic [7:0] A_STATUS = 8'h28;
  localparam logic [7:0] A_MASK = 8'h2c;
  localparam logic [7:0] A_RECIDX = 8'h30;
  localparam logic [7:0] A_RECA = 8'h34;
  localparam logic [7:0] A_RECB = 8'h38;
  localparam logic [7:0] A_RECTS = 8'h3c;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0001_0000;  // ON events kept
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // Node operating modes
  localparam logic [2:0] MODE_ON = 3'h0;
  localparam logic [2:0] MODE_BLK = 3'h1;
  localparam logic [2:0] MODE_TEST = 3'h2;
  localparam logic [2:0] MODE_TBLK = 3'h3;
  localparam logic [2:0] MODE_OFF = 3'h4;
  // Stage conditions
  localparam logic [1:0] C_NORMAL = 2'h0;
  localparam logic [1:0] C_START = 2'h1;
  localparam logic [1:0] C_TRIP = 2'h2;
  localparam logic [1:0] C_BLOCKED = 2'h3;
  // Stage state
  typedef enum logic [3:0] {
    S_IDLE = 4'h1, S_START = 4'h2, S_TRIP = 4'h4, S_BLOCKED = 4'h8
  } fps_stage_t;
endpackage : fps_pkg

// >>> test/fps_meas_src.sv
/* Measurement source: three frequency references and a voltage.
   Assumes bench commands on aclk; updates once a clock like a tracker. */
`timescale 1ns/10ps
module fps_meas_src (
  // Clock
  input wire logic aclk,
  // Commands from the bench
  input wire logic [13:0] f_cmd,
  input wire logic [1:0] sel,
  input wire logic [13:0] v_cmd,
  // Measured quantities
  output logic [13:0] freq_pri,
  output logic [13:0] freq_sec,
  output logic [13:0] freq_ter,
  output logic [13:0] volt_meas
);
  // Idle references sit at 50 Hz so only one source can pick up
  localparam logic [13:0] F_NOM = 14'h1388;
  ////////////////////////////////////////////////////////////////////
  // Only the selected reference carries the commanded frequency
  always_ff @(posedge aclk) begin
    freq_pri <= (sel == 2'h0) ? f_cmd : F_NOM;
    freq_sec <= (sel == 2'h1) ? f_cmd : F_NOM;
    freq_ter <= (sel == 2'h2) ? f_cmd : F_NOM;
    volt_meas <= v_cmd;
  end
endmodule : fps_meas_src

// >>> test/fps_stages_test.sv
/* Bench: AXI4-Lite tasks, a pick-up model and stage scenarios.
   Assumes a 20-cycle program tick so stage timing stays short. */
`timescale 1ns/10ps
module fps_stages_test import fps_pkg::*;;
  localparam int TK = 20; // Short tick
  localparam int LV = 32'(LVL_OVER_RST);
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [13:0] f_cmd = 14'h1388;
  logic [13:0] v_cmd = 14'h0000;
  logic [1:0] sel = 2'h0;
  logic [7:0] block_in = 8'h00;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic [7:0] start_o, trip_o, blocked_o;
  logic [13:0] fp, fs, ft, vm;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 22283;
  int st = 1; // Model: stage 0 picked up
  int fv;
  int tab[4] = '{LV - 1, LV - 2, LV, LV + 1};
  always #2 aclk = ~aclk;
  fps_meas_src src_u (.aclk(aclk), .f_cmd(f_cmd), .sel(sel),
    .v_cmd(v_cmd), .freq_pri(fp), .freq_sec(fs), .freq_ter(ft),
    .volt_meas(vm));
  fps_stages #(.TICK_CYCLES(TK)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .freq_pri(fp), .freq_sec(fs), .freq_ter(ft),
    .volt_meas(vm), .block_in(block_in), .start_o(start_o),
    .trip_o(trip_o), .blocked_o(blocked_o), .irq(irq));
  ////////////////////////////////////////////////////////////////////
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Verdict and stop
  task end_of_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  // Hang guard, well above the expected run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      end_of_test;
    end
  end
  // Write: address and data together, bready held until bvalid
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!aw && awready === 1'b1) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end while (!(aw && w));
    while (bvalid !== 1'b1) @(posedge aclk);
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr
  // Read: data and response taken at the rvalid edge
  task rdt(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : rdt
  // Level with use flag; delay code 2 carries the flag bit
  task stg(input logic [31:0] s, input logic [13:0] lvl);
    wr(A_SETIDX, s);
    wr(A_SETDATA, {18'h00002, lvl});
  endtask : stg
  task tk(input int n);
    repeat (n * TK) @(posedge aclk);
  endtask : tk
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rdt(A_CTRL);
    chk(rd, CTRL_RST);
    rdt(A_FORCE);
    chk(rd, 32'h0);
    rdt(8'h40);
    chk(32'(rsp), 32'(RESP_ERR));
    wr(8'h40, 32'h0);
    chk(32'(rsp), 32'(RESP_ERR));
    // Mode write ignored while individual mode is not allowed
    wr(A_CTRL, 32'h0001_0400);
    rdt(A_CTRL);
    chk(rd, CTRL_RST);
    wr(A_GLOBAL, 32'h1);
    stg(0, LVL_OVER_RST);
    stg(4, LVL_UNDER_RST);
    wr(A_MASK, 32'hf);
    wr(A_CTRL, 32'h0001_0011);
    f_cmd <= 14'(LV + 1);
    tk(5);
    chk(32'(start_o), 32'h01);
    chk(32'(trip_o), 32'h01);
    chk(32'(irq), 32'h1);
    // Last kept event is the trip ON edge; first record the start
    rdt(A_EVENT);
    chk(32'(rd[7:0]), 32'h28);
    rdt(A_RECA);
    chk(32'(rd[8:0]), 32'h020);
    rdt(A_RECB);
    chk(32'(rd[29:16]), 32'(LV + 1));
    rdt(A_COND);
    chk(32'(rd[1:0]), 32'(C_TRIP));
    wr(A_GLOBAL, 32'h3);
    wr(A_FORCE, 32'h3);
    rdt(A_COND);
    chk(32'(rd[1:0]), 32'(C_BLOCKED));
    wr(A_GLOBAL, 32'h1);
    // Test mode keeps trip off the port, Off clears every output
    wr(A_CTRL, 32'h0001_0211);
    @(posedge aclk);
    chk(32'({trip_o[0], start_o[0]}), 32'h1);
    wr(A_CTRL, 32'h0001_0411);
    repeat (3) @(posedge aclk);
    chk(32'({trip_o[0], start_o[0]}), 32'h0);
    wr(A_CTRL, 32'h0001_0011);
    tk(5);
    // Boundary table, then random levels near the pick-up
    for (int i = 0; i < 10; i++) begin
      fv = (i < 4) ? tab[i] : LV - 4 + ($random(seed) & 7);
      st = st ? int'(fv > LV - 2) : int'(fv > LV);
      f_cmd <= 14'(fv);
      tk(5);
      chk(32'(start_o[0]), 32'(st));
    end
    // Interrupt follows status and mask one cycle late
    wr(A_MASK, 32'h0);
    @(posedge aclk);
    chk(32'(irq), 32'h0);
    wr(A_STATUS, 32'hf);
    wr(A_MASK, 32'hf);
    @(posedge aclk);
    chk(32'(irq), 32'h0);
    f_cmd <= 14'(LV - 4);
    tk(5);
    block_in <= 8'h01;
    f_cmd <= 14'(LV + 5);
    tk(5);
    chk(32'({blocked_o[0], start_o[0]}), 32'h2);
    block_in <= 8'h00;
    wr(A_UVTHR, 32'h100);
    f_cmd <= LVL_UNDER_RST - 14'h0001;
    tk(5);
    chk(32'(start_o[4]), 32'h0);
    chk(32'(blocked_o[4]), 32'h1);
    // Blocked stage waits for release before a fresh pick-up
    f_cmd <= 14'h1388;
    v_cmd <= 14'h0200;
    tk(5);
    f_cmd <= LVL_UNDER_RST - 14'h0001;
    tk(5);
    chk(32'(start_o[4]), 32'h1);
    f_cmd <= 14'(LV + 1);
    sel <= 2'h1;
    wr(A_CTRL, 32'h0001_1011);
    tk(5);
    chk(32'(start_o), 32'h01);
    wr(A_GROUP, 32'h1);
    tk(5);
    chk(32'(start_o), 32'h00);
    rdt(A_CTRL);
    chk(rd, 32'h0001_1011);
    // Round robin needs a full lap with a steady frequency
    tk(10);
    rdt(A_RATIO);
    chk(rd, 32'(int'(LVL_UNDER_RST) * 1000 / (LV + 1)));
    end_of_test;
  end
endmodule : fps_stages_test
